// file: isd_core.sv
// Instruction sequencer: fetch, execute, skip, call and return.
// Assumes program memory answers combinationally at the addressed word
// and the file space outside the core returns data in the same cycle.
`timescale 1ns/1ps
// What this block does
// RULE_01 - Increment, store, skip when zero
// RULE_02 - Decrement, store, skip when zero, no flags
// RULE_03 - Rotates pass through carry, only carry changes
// RULE_04 - OR accumulator with file, zero flag only
// RULE_05 - XOR accumulator with file, zero flag only
// RULE_06 - Skip next when tested bit clear
// RULE_07 - Skip next when tested bit set
// RULE_08 - Literal minus accumulator, sets C DC Z
// RULE_09 - OR literal into accumulator, zero flag
// RULE_10 - XOR literal into accumulator, zero flag
// RULE_11 - Return loading literal, two cycles, no flags
// RULE_12 - Standby sets watchdog flag, clears power-down flag
// RULE_13 - Port read-modify-write uses pin levels
// RULE_14 - Timer count write clears assigned prescaler
// RULE_15 - Branch or true test costs flush cycle
// RULE_16 - Low seven bits address, bit seven destination
// RULE_17 - Remaining instructions per encoding table
module isd_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cycle_en_i,
    // Program memory
    output logic [12:0] prog_addr_o,
    input wire logic [13:0] prog_data_i,
    // File register space
    output logic [6:0] file_addr_o,
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] pin_level_i,
    input wire logic addr_is_port_i,
    output logic [7:0] file_wdata_o,
    output logic file_we_o,
    // Timer and power state
    input wire logic prescaler_on_timer_i,
    output logic prescaler_clear_o,
    output logic standby_o,
    output logic watchdog_clear_o,
    // Status view
    output logic [7:0] acc_o,
    output logic [4:0] status_o
);
    import isd_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    phase_t phase_r;
    logic [12:0] pc_r;
    logic [7:0] acc_r;
    logic [4:0] flags_r;
    logic standby_r;
    logic [12:0] stack_r [STACK_DEPTH];
    logic [2:0] sp_r;
    logic [13:0] instr;
    logic exec;
    logic is_call;
    logic is_goto;
    logic is_ret;
    logic branch;
    logic [12:0] pc_nxt;

    file_port_if fp ();
    isd_alu u_alu (
        .fp(fp)
    );

    assign instr = prog_data_i;
    assign exec = cycle_en_i && !reset_i && phase_r == PH_FETCH && !standby_r;
    assign file_addr_o = instr[6:0]; // RULE_16
    // Port sources come from the pins, not the latch, so a pin held low by
    // another driver is written back low.
    assign fp.opnd = addr_is_port_i ? pin_level_i : file_rdata_i; // RULE_13
    assign fp.acc = acc_r;
    assign fp.instr = instr;
    assign fp.carry_in = flags_r[ST_CARRY];

    assign is_call = instr[13:11] == 3'b100;
    assign is_goto = instr[13:11] == 3'b101;
    assign is_ret = instr == OP_RETURN || instr == OP_RET_INT || instr[13:10] == 4'b1101; // RULE_11
    assign branch = is_call || is_goto || is_ret || fp.skip; // RULE_15

    always_comb begin
        pc_nxt = pc_r + 13'h0001;
        if (is_call || is_goto) begin
            pc_nxt = {2'h0, instr[10:0]};
        end else if (is_ret) begin
            pc_nxt = stack_r[sp_r - 3'h1];
        end else if (fp.skip) begin
            pc_nxt = pc_r + 13'h0002; // RULE_01
        end
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_r <= PH_FETCH;
        end else if (cycle_en_i) begin
            phase_r <= (exec && branch) ? PH_FLUSH : PH_FETCH; // RULE_15
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pc_r <= PC_RESET;
            sp_r <= 3'h0;
        end else if (exec) begin
            pc_r <= pc_nxt;
            if (is_call) begin
                stack_r[sp_r] <= pc_r + 13'h0001;
                sp_r <= sp_r + 3'h1;
            end else if (is_ret) begin
                sp_r <= sp_r - 3'h1;
            end
        end
    end

    assign prog_addr_o = pc_r;

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_r <= ACC_RESET;
        end else if (exec && !fp.dest_file) begin
            acc_r <= fp.result; // RULE_16
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flags_r <= FLAGS_RESET;
        end else if (exec) begin
            for (int i = 0; i < 3; i++) begin
                if (fp.flag_we[i]) begin
                    flags_r[i] <= fp.flag_val[i];
                end
            end
            if (instr == OP_STANDBY) begin
                flags_r[ST_WDOG] <= 1'b1; // RULE_12
                flags_r[ST_PDOWN] <= 1'b0;
            end else if (instr == OP_CLR_WDOG) begin
                flags_r[ST_WDOG] <= 1'b1;
                flags_r[ST_PDOWN] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            standby_r <= 1'b0;
        end else if (exec && instr == OP_STANDBY) begin
            standby_r <= 1'b1; // RULE_12
        end
    end

    assign file_we_o = exec && fp.dest_file && instr[13:12] != 2'h3;
    assign file_wdata_o = fp.result;
    assign prescaler_clear_o = file_we_o && file_addr_o == ADDR_FIRST_TIMER && prescaler_on_timer_i; // RULE_14
    assign standby_o = standby_r;
    assign watchdog_clear_o = exec && (instr == OP_CLR_WDOG || instr == OP_STANDBY);
    assign acc_o = acc_r;
    assign status_o = flags_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_inc_skip;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h0F && fp.result == 8'h00 |=> phase_r == PH_FLUSH;
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment skip missed"); // RULE_01

    property p_dec_flags;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h0B |=> $stable(flags_r);
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("decrement skip changed flags"); // RULE_02

    property p_rot_zero;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:9] == 5'h06 |=> flags_r[ST_ZERO] == $past(flags_r[ST_ZERO]);
    endproperty
    a_rot_zero: assert property (p_rot_zero) else $error("rotate touched zero"); // RULE_03

    property p_or_zero;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h04 |=> flags_r[ST_ZERO] == ($past(acc_r | fp.opnd) == 8'h00);
    endproperty
    a_or_zero: assert property (p_or_zero) else $error("or zero flag wrong"); // RULE_04

    property p_btest_clear;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:10] == 4'h6 && !fp.opnd[instr[9:7]] |=> phase_r == PH_FLUSH;
    endproperty
    a_btest_clear: assert property (p_btest_clear) else $error("bit clear skip missed"); // RULE_06

    property p_btest_set;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:10] == 4'h7 && !fp.opnd[instr[9:7]] |=> phase_r == PH_FETCH;
    endproperty
    a_btest_set: assert property (p_btest_set) else $error("bit set took two cycles"); // RULE_07

    property p_sub_acc_from_literal;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:9] == 5'h1E |=> acc_r == $past(instr[7:0] - acc_r);
    endproperty
    a_sub_acc_from_literal: assert property (p_sub_acc_from_literal) else $error("literal subtract wrong"); // RULE_08

    property p_standby;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr == OP_STANDBY |=> standby_o && !flags_r[ST_PDOWN] && flags_r[ST_WDOG];
    endproperty
    a_standby: assert property (p_standby) else $error("standby flags wrong"); // RULE_12

    property p_prescale;
        @(posedge clk_i) disable iff (reset_i)
        prescaler_clear_o |-> file_we_o && prescaler_on_timer_i;
    endproperty
    a_prescale: assert property (p_prescale) else $error("spurious prescaler clear"); // RULE_14

    property p_xor_zero;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h06 |=> flags_r[ST_ZERO] == ($past(acc_r ^ fp.opnd) == 8'h00);
    endproperty
    a_xor_zero: assert property (p_xor_zero) else $error("xor zero flag wrong"); // RULE_05

    property p_or_literal;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h38 |=> acc_r == $past(acc_r | instr[7:0]) && flags_r[ST_ZERO] == (acc_r == 8'h00);
    endproperty
    a_or_literal: assert property (p_or_literal) else $error("or literal wrong"); // RULE_09

    property p_xor_literal;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h3A |=> acc_r == $past(acc_r ^ instr[7:0]) && flags_r[ST_ZERO] == (acc_r == 8'h00);
    endproperty
    a_xor_literal: assert property (p_xor_literal) else $error("xor literal wrong"); // RULE_10

    property p_ret_literal;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:10] == 4'hD |=> phase_r == PH_FLUSH && acc_r == $past(instr[7:0]) && $stable(flags_r);
    endproperty
    a_ret_literal: assert property (p_ret_literal) else $error("return with literal wrong"); // RULE_11

    property p_port_source;
        @(posedge clk_i) disable iff (reset_i)
        exec && addr_is_port_i && instr[13:7] == 7'h11 |-> file_we_o && file_wdata_o == pin_level_i;
    endproperty
    a_port_source: assert property (p_port_source) else $error("port source not pins"); // RULE_13

    property p_prescale_hit;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:12] == 2'h0 && instr[7] && instr[6:0] == ADDR_FIRST_TIMER && prescaler_on_timer_i
        |-> prescaler_clear_o;
    endproperty
    a_prescale_hit: assert property (p_prescale_hit) else $error("prescaler clear missed"); // RULE_14

    property p_jump_flush;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:12] == 2'h2 |=> phase_r == PH_FLUSH && pc_r == $past({2'h0, instr[10:0]});
    endproperty
    a_jump_flush: assert property (p_jump_flush) else $error("jump without flush"); // RULE_15

    property p_flush_idle;
        @(posedge clk_i) disable iff (reset_i)
        phase_r == PH_FLUSH |-> !file_we_o ##1 ($stable(acc_r) && $stable(flags_r));
    endproperty
    a_flush_idle: assert property (p_flush_idle) else $error("flush cycle did work"); // RULE_15

    property p_dest_select;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:12] == 2'h0 |-> file_we_o == instr[7] && file_addr_o == instr[6:0];
    endproperty
    a_dest_select: assert property (p_dest_select) else $error("destination select wrong"); // RULE_16

    property p_rot_carry;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h0D |=> flags_r[ST_CARRY] == $past(fp.opnd[7]);
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong"); // RULE_03

    property p_dec_skip;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:8] == 6'h0B && fp.opnd == 8'h01 |=> phase_r == PH_FLUSH;
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip missed"); // RULE_02

    property p_add_literal;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr[13:9] == 5'h1F |=> acc_r == $past(instr[7:0] + acc_r);
    endproperty
    a_add_literal: assert property (p_add_literal) else $error("add literal wrong"); // RULE_17

    property p_clr_wdog;
        @(posedge clk_i) disable iff (reset_i)
        exec && instr == OP_CLR_WDOG |=> flags_r[ST_WDOG] && flags_r[ST_PDOWN] && !standby_o;
    endproperty
    a_clr_wdog: assert property (p_clr_wdog) else $error("watchdog clear flags wrong"); // RULE_17
endmodule

// file: isd_pkg.sv
// Shared constants for the instruction set decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
package isd_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam logic [6:0] ADDR_FIRST_TIMER = 7'h01;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam int unsigned ST_CARRY = 0;
    localparam int unsigned ST_HALF = 1;
    localparam int unsigned ST_ZERO = 2;
    localparam int unsigned ST_PDOWN = 3;
    localparam int unsigned ST_WDOG = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h18;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam int unsigned STACK_DEPTH = 8;
    localparam logic [13:0] OP_STANDBY = 14'h0063;
    localparam logic [13:0] OP_CLR_WDOG = 14'h0064;
    localparam logic [13:0] OP_RETURN = 14'h0008;
    localparam logic [13:0] OP_RET_INT = 14'h0009;
    typedef enum logic [1:0] {
        PH_FETCH = 2'h1,
        PH_FLUSH = 2'h2
    } phase_t;
endpackage

// file: file_port_if.sv
// File-register access bundle between the core and its ALU.
// Assumes one clock domain; reads are combinational.
`timescale 1ns/1ps
interface file_port_if;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [13:0] instr;
    logic carry_in;
    logic [7:0] result;
    logic [2:0] flag_we;
    logic [2:0] flag_val;
    logic dest_file;
    logic skip;
    modport core (output acc, opnd, instr, carry_in, input result, flag_we, flag_val, dest_file, skip);
    modport alu (input acc, opnd, instr, carry_in, output result, flag_we, flag_val, dest_file, skip);
endinterface

// file: isd_alu.sv
// Combinational datapath for byte, bit and literal instructions.
// Assumes operand already chosen by the core (pins for ports).
`timescale 1ns/1ps
module isd_alu (
    file_port_if.alu fp
);
    import isd_pkg::*;
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] a;
    logic [7:0] b;
    logic sub;
    logic [2:0] bsel;
    always_comb begin
        fp.result = 8'h00;
        fp.flag_we = 3'h0;
        fp.flag_val = 3'h0;
        fp.dest_file = fp.instr[7]; // RULE_16
        fp.skip = 1'b0;
        bsel = fp.instr[9:7];
        a = 8'h00;
        b = 8'h00;
        sub = 1'b0;
        sum = 9'h000;
        half = 5'h00;
        if (fp.instr[13:12] == 2'h0) begin
            unique case (fp.instr[11:8])
                4'h7: begin a = fp.opnd; b = fp.acc; end // RULE_17
                4'h2: begin a = fp.opnd; b = fp.acc; sub = 1'b1; end
                default: ;
            endcase
        end else if (fp.instr[13:12] == 2'h3) begin
            if (fp.instr[11:9] == 3'h7) begin a = fp.instr[7:0]; b = fp.acc; end
            if (fp.instr[11:9] == 3'h6) begin a = fp.instr[7:0]; b = fp.acc; sub = 1'b1; end // RULE_08
        end
        sum = sub ? ({1'b0, a} + {1'b0, ~b} + 9'h001) : ({1'b0, a} + {1'b0, b});
        half = sub ? ({1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
        unique case (fp.instr[13:12])
            2'h0: begin
                unique case (fp.instr[11:8])
                    4'h0: fp.result = fp.acc;
                    4'h1: begin fp.result = 8'h00; fp.flag_we = 3'h4; end
                    4'h2, 4'h7: begin fp.result = sum[7:0]; fp.flag_we = 3'h7; end
                    4'h3: begin fp.result = fp.opnd - 8'h01; fp.flag_we = 3'h4; end
                    4'h4: begin fp.result = fp.acc | fp.opnd; fp.flag_we = 3'h4; end // RULE_04
                    4'h5: begin fp.result = fp.acc & fp.opnd; fp.flag_we = 3'h4; end
                    4'h6: begin fp.result = fp.acc ^ fp.opnd; fp.flag_we = 3'h4; end // RULE_05
                    4'h8: begin fp.result = fp.opnd; fp.flag_we = 3'h4; end
                    4'h9: begin fp.result = ~fp.opnd; fp.flag_we = 3'h4; end
                    4'hA: begin fp.result = fp.opnd + 8'h01; fp.flag_we = 3'h4; end
                    4'hB: begin
                        fp.result = fp.opnd - 8'h01; // RULE_02
                        fp.skip = (fp.result == 8'h00);
                    end
                    4'hC: begin
                        fp.result = {fp.carry_in, fp.opnd[7:1]}; // RULE_03
                        fp.flag_we = 3'h1;
                        fp.flag_val[ST_CARRY] = fp.opnd[0];
                    end
                    4'hD: begin
                        fp.result = {fp.opnd[6:0], fp.carry_in}; // RULE_03
                        fp.flag_we = 3'h1;
                        fp.flag_val[ST_CARRY] = fp.opnd[7];
                    end
                    4'hE: fp.result = {fp.opnd[3:0], fp.opnd[7:4]};
                    4'hF: begin
                        fp.result = fp.opnd + 8'h01; // RULE_01
                        fp.skip = (fp.result == 8'h00);
                    end
                endcase
                if (fp.instr[11:8] == 4'h0 || fp.instr[11:8] == 4'h1) begin
                    fp.dest_file = fp.instr[7];
                end
            end
            2'h1: begin
                fp.dest_file = 1'b1;
                fp.result = fp.opnd;
                unique case (fp.instr[11:10])
                    2'h0: fp.result[bsel] = 1'b0;
                    2'h1: fp.result[bsel] = 1'b1;
                    2'h2: begin fp.skip = ~fp.opnd[bsel]; fp.dest_file = 1'b0; fp.result = fp.acc; end // RULE_06
                    2'h3: begin fp.skip = fp.opnd[bsel]; fp.dest_file = 1'b0; fp.result = fp.acc; end // RULE_07
                endcase
            end
            2'h3: begin
                fp.dest_file = 1'b0;
                unique casez (fp.instr[11:8])
                    4'b00??: fp.result = fp.instr[7:0];
                    4'b01??: fp.result = fp.instr[7:0]; // RULE_11
                    4'b1000: begin fp.result = fp.acc | fp.instr[7:0]; fp.flag_we = 3'h4; end // RULE_09
                    4'b1001: begin fp.result = fp.acc & fp.instr[7:0]; fp.flag_we = 3'h4; end
                    4'b1010: begin fp.result = fp.acc ^ fp.instr[7:0]; fp.flag_we = 3'h4; end // RULE_10
                    4'b1011: fp.result = fp.acc;
                    4'b110?, 4'b111?: begin fp.result = sum[7:0]; fp.flag_we = 3'h7; end
                endcase
            end
            default: begin
                fp.dest_file = 1'b0;
                fp.result = fp.acc;
            end
        endcase
        fp.flag_val[ST_ZERO] = (fp.result == 8'h00);
        if (fp.flag_we[ST_CARRY] && fp.flag_we[ST_HALF]) begin
            fp.flag_val[ST_CARRY] = sum[8];
            fp.flag_val[ST_HALF] = half[4];
        end
    end
endmodule

// file: prog_file_model.sv
// Far-side model: program memory and the file register space around the core.
// Assumes the core reads both combinationally and writes on its own clock edge.
`timescale 1ns/1ps
module prog_file_model (
    // Clock
    input wire logic clk_i,
    // Program memory
    input wire logic [12:0] prog_addr_i,
    output logic [13:0] prog_data_o,
    // File space
    input wire logic [6:0] file_addr_i,
    input wire logic [7:0] file_wdata_i,
    input wire logic file_we_i,
    output logic [7:0] file_rdata_o
);
    logic [13:0] rom [0:255];
    logic [7:0] ram [0:127];

    // Only 256 words are held, so higher addresses alias; tests stay low
    assign prog_data_o = rom[prog_addr_i[7:0]];
    assign file_rdata_o = ram[file_addr_i];

    always @(posedge clk_i) begin
        if (file_we_i === 1'b1) begin
            ram[file_addr_i] <= file_wdata_i;
        end
    end
endmodule

// file: instruction_set_decoder_bench.sv
// Self-checking bench for the instruction sequencer and its datapath.
// Assumes isd_pkg and the far-side model are compiled first.
`timescale 1ns/1ps
module instruction_set_decoder_bench;
    import isd_pkg::*;
    logic clk_i, reset_i, cycle_en_i, addr_is_port_i, prescaler_on_timer_i;
    logic [12:0] prog_addr_o;
    logic [13:0] prog_data_i;
    logic [6:0] file_addr_o;
    logic [7:0] file_rdata_i, pin_level_i, file_wdata_o, acc_o;
    logic file_we_o, prescaler_clear_o, standby_o, watchdog_clear_o;
    logic [4:0] status_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int clr_cnt, wd_cnt;

    isd_core i_dut (.clk_i(clk_i), .reset_i(reset_i), .cycle_en_i(cycle_en_i), .prog_addr_o(prog_addr_o),
        .prog_data_i(prog_data_i), .file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i),
        .pin_level_i(pin_level_i), .addr_is_port_i(addr_is_port_i), .file_wdata_o(file_wdata_o),
        .file_we_o(file_we_o), .prescaler_on_timer_i(prescaler_on_timer_i),
        .prescaler_clear_o(prescaler_clear_o), .standby_o(standby_o),
        .watchdog_clear_o(watchdog_clear_o), .acc_o(acc_o), .status_o(status_o));

    prog_file_model i_mem (.clk_i(clk_i), .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
        .file_addr_i(file_addr_o), .file_wdata_i(file_wdata_o), .file_we_i(file_we_o),
        .file_rdata_o(file_rdata_i));

    // Address 0x06 stands for an I/O port whose pins differ from its latch
    always_comb addr_is_port_i = (file_addr_o == 7'h06);

    // Pulses are counted so a registered or combinational pulse both pass
    always @(posedge clk_i) begin
        if (prescaler_clear_o === 1'b1) clr_cnt++;
        if (watchdog_clear_o === 1'b1) wd_cnt++;
    end

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Hold reset, clear program and counters; caller loads words then calls go
    task automatic prep();
        reset_i = 1'b1;
        for (int i = 0; i < 256; i++) i_mem.rom[i] = 14'h0000;
        run(2);
        clr_cnt = 0;
        wd_cnt = 0;
    endtask

    task automatic go();
        reset_i = 1'b0;
    endtask

    task automatic inc_skip();
        prep();
        i_mem.ram[7'h20] = 8'hFF;
        i_mem.rom[0] = 14'h0FA0;
        i_mem.rom[1] = 14'h3011;
        i_mem.rom[2] = 14'h3022;
        go();
        run(2);
        check("flush acc", acc_o, 8'h00);
        run(1);
        check("inc acc", acc_o, 8'h22);
        check("inc file", i_mem.ram[7'h20], 8'h00);
        check("inc status", status_o, FLAGS_RESET);
    endtask

    task automatic dec_noskip();
        prep();
        i_mem.ram[7'h21] = 8'h02;
        i_mem.rom[0] = 14'h0B21;
        i_mem.rom[1] = 14'h3A0F;
        i_mem.rom[2] = 14'h0BA1;
        i_mem.rom[3] = 14'h0BA1;
        i_mem.rom[4] = 14'h30FF;
        i_mem.rom[5] = 14'h3A0F;
        go();
        run(1);
        check("dec acc", acc_o, 8'h01);
        run(1);
        check("xor_literal_acc acc", acc_o, 8'h0E);
        check("dec file", i_mem.ram[7'h21], 8'h02);
        check("dec status", status_o, FLAGS_RESET);
        run(2);
        check("dec to zero", i_mem.ram[7'h21], 8'h00);
        run(2);
        check("dec skip acc", acc_o, 8'h01);
    endtask

    task automatic rotates();
        prep();
        i_mem.ram[7'h22] = 8'h81;
        i_mem.rom[0] = 14'h0DA2;
        i_mem.rom[1] = 14'h0C22;
        go();
        run(1);
        check("rlf file", i_mem.ram[7'h22], 8'h02);
        check("rlf status", status_o, 5'h19);
        run(1);
        check("rrf acc", acc_o, 8'h81);
        check("rrf status", status_o, 5'h18);
    endtask

    task automatic logic_ops();
        prep();
        i_mem.ram[7'h23] = 8'h5A;
        i_mem.rom[0] = 14'h0423;
        i_mem.rom[1] = 14'h06A3;
        i_mem.rom[2] = 14'h3800;
        i_mem.rom[3] = 14'h3C5A;
        i_mem.rom[4] = 14'h3E8F;
        i_mem.rom[5] = 14'h3EF1;
        go();
        run(1);
        check("ior acc", acc_o, 8'h5A);
        run(1);
        check("xor file", i_mem.ram[7'h23], 8'h00);
        check("xor status", status_o, 5'h1C);
        run(1);
        check("or_literal_acc status", status_o, 5'h18);
        run(1);
        check("sub acc", acc_o, 8'h00);
        check("sub status", status_o, 5'h1F);
        run(1);
        check("add acc", acc_o, 8'h8F);
        run(1);
        check("add carry", acc_o, 8'h80);
        check("add status", status_o, 5'h1B);
    endtask

    task automatic bit_tests();
        prep();
        i_mem.ram[7'h24] = 8'h04;
        i_mem.rom[0] = 14'h1924;
        i_mem.rom[1] = 14'h3033;
        i_mem.rom[2] = 14'h1D24;
        i_mem.rom[3] = 14'h3044;
        i_mem.rom[4] = 14'h1824;
        i_mem.rom[5] = 14'h3066;
        i_mem.rom[6] = 14'h1C24;
        i_mem.rom[7] = 14'h3055;
        go();
        run(2);
        check("bit_test_skip_clear acc", acc_o, 8'h33);
        run(2);
        check("bit_test_skip_set skip", acc_o, 8'h33);
        run(2);
        check("bit_test_skip_clear skip", acc_o, 8'h33);
        run(2);
        check("bit_test_skip_set acc", acc_o, 8'h55);
        check("bit status", status_o, FLAGS_RESET);
    endtask

    task automatic call_ret();
        prep();
        i_mem.rom[0] = 14'h2005;
        i_mem.rom[1] = 14'h3066;
        i_mem.rom[5] = 14'h3477;
        cycle_en_i = 1'b0;
        go();
        run(2);
        check("stall pc", prog_addr_o, 13'h0000);
        cycle_en_i = 1'b1;
        run(4);
        check("return_with_literal acc", acc_o, 8'h77);
        check("return_with_literal pc", prog_addr_o, 13'h0001);
        check("return_with_literal status", status_o, FLAGS_RESET);
    endtask

    task automatic port_timer();
        prep();
        i_mem.ram[7'h06] = 8'hFF;
        i_mem.ram[7'h01] = 8'h77;
        i_mem.rom[0] = 14'h0886;
        i_mem.rom[1] = 14'h0181;
        i_mem.rom[2] = 14'h0081;
        prescaler_on_timer_i = 1'b1;
        go();
        run(2);
        check("port file", i_mem.ram[7'h06], 8'h3C);
        check("timer file", i_mem.ram[7'h01], 8'h00);
        prescaler_on_timer_i = 1'b0;
        run(2);
        check("clear count", clr_cnt, 16'd1);
    endtask

    task automatic standby();
        prep();
        i_mem.rom[0] = OP_CLR_WDOG;
        i_mem.rom[1] = OP_STANDBY;
        i_mem.rom[2] = 14'h3011;
        go();
        run(2);
        check("sleep status", status_o, 5'h10);
        run(2);
        check("sleep acc", acc_o, 8'h00);
        check("standby", standby_o, 1'b1);
        check("wdog pulses", wd_cnt, 16'd2);
    endtask

    initial begin
        #300000;
        error_cnt++;
        end_sim();
    end

    initial begin
        reset_i = 1'b1;
        cycle_en_i = 1'b1;
        pin_level_i = 8'h3C;
        for (int i = 0; i < 256; i++) i_mem.rom[i] = 14'h0000;
        prescaler_on_timer_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        inc_skip();
        dec_noskip();
        rotates();
        logic_ops();
        bit_tests();
        call_ret();
        port_timer();
        standby();
        end_sim();
    end
endmodule
